/* File: hdl/srqh_top.sv */
module srqh_top (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire srqh_pkg::srqh_beat_t req,
  output logic                   exec_valid,
  input  wire logic              exec_ready,
  output srqh_pkg::srqh_exec_t   exec_cmd,
  output logic                   exec_cancel,
  input  wire logic              tgt_valid,
  output logic                   tgt_ready,
  input  wire srqh_pkg::srqh_tgt_t tgt,
  input  wire logic              tmf_abort,
  input  wire logic              tmf_reset,
  input  wire logic              unplug,
  output logic                   cpl_valid,
  input  wire logic              cpl_ready,
  output srqh_pkg::srqh_cpl_t    cpl
);

  typedef struct packed {
    srqh_pkg::srqh_fsm_t  fsm;
    logic [8:0]           idx;
    logic                 short_hdr;
    logic [7:0][7:0]      lun;
    srqh_pkg::srqh_exec_t cmd;
    srqh_pkg::srqh_cpl_t  cpl;
    logic                 cancel;
    logic                 f_inout;
    logic                 f_pi;
    logic                 map_simple;
    logic [31:0]          sense_size;
    logic [7:0]           cdb_size;
    logic [7:0]           max_target;
    logic                 rst_pend;
    logic [15:0]          done_cnt;
    logic [7:0]           last_resp;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [31:0]          rdata;
  } srqh_state_t;

  srqh_state_t s_q;
  srqh_state_t s_d;

  // Header length depends on the configured block size and the feature
  function automatic logic [8:0] hdr_len(input logic [7:0] cdb, input logic pi);
    hdr_len = srqh_pkg::OFS_CDB + {1'b0, cdb} + (pi ? srqh_pkg::PI_LEN : 9'h000);
  endfunction : hdr_len

  function automatic logic is_report(input logic [7:0][7:0] l);
    is_report = l[0] == srqh_pkg::LUN_REPORT_B0 && l[1] == srqh_pkg::LUN_REPORT_B1 &&
                l[2] == 8'h00 && l[3] == 8'h00 && l[7:4] == 32'h0000_0000;
  endfunction : is_report

  function automatic logic is_flat(input logic [7:0][7:0] l);
    is_flat = l[0] == srqh_pkg::LUN_FLAT_B0 && l[7:4] == 32'h0000_0000;
  endfunction : is_flat

  logic ahb_go;
  logic both_dir;
  assign ahb_go   = hsel && htrans[1] && hready;
  assign both_dir = s_q.cmd.out_len != 32'h0 && s_q.cmd.in_len != 32'h0;

  // Next state: request parse, decision, target hand-off, completion, registers
  always_comb begin
    logic [8:0]  i;
    logic [8:0]  c;
    logic [8:0]  p;
    logic [8:0]  hl;
    logic [31:0] rd;
    i  = s_q.idx;
    c  = i - srqh_pkg::OFS_CDB;
    p  = c - {1'b0, s_q.cmd.cdb_len};
    hl = hdr_len(s_q.cmd.cdb_len, s_q.f_pi);
    rd = 32'h0000_0000;
    s_d = s_q;
    s_d.cancel = 1'b0;
    case (s_q.fsm)
      srqh_pkg::S_HDR: begin
        if (s_q.rst_pend && i == 9'h000) begin
          // Nothing outstanding, so the device reset takes effect now
          s_d.rst_pend   = 1'b0;
          s_d.sense_size = srqh_pkg::SENSE_RST;
          s_d.cdb_size   = srqh_pkg::CDB_RST;
        end else if (req_valid) begin
          if (i == 9'h000) begin
            s_d.cmd            = '0;
            s_d.cmd.queue      = req.queue;
            s_d.cmd.out_len    = req.out_len;
            s_d.cmd.in_len     = req.in_len;
            s_d.cmd.cdb_len    = s_q.cdb_size;
            s_d.short_hdr      = 1'b0;
            hl                 = hdr_len(s_q.cdb_size, s_q.f_pi);
          end
          // Header bytes are copied out, nothing is written back
          if (i < srqh_pkg::OFS_TAG) begin
            s_d.lun[i[2:0]] = req.data;
          end else if (i < srqh_pkg::OFS_ATTR) begin
            s_d.cmd.tag[8*i[2:0] +: 8] = req.data;
          end else if (i == srqh_pkg::OFS_ATTR) begin
            s_d.cmd.attr = s_q.map_simple ? srqh_pkg::ATTR_SIMPLE : req.data;
          end else if (i == srqh_pkg::OFS_PRIO) begin
            s_d.cmd.prio = req.data;
          end else if (i == srqh_pkg::OFS_CRN) begin
            s_d.cmd.crn = req.data;
          end else if (c < {1'b0, s_q.cmd.cdb_len}) begin
            if (c < 9'(srqh_pkg::CDB_KEEP)) begin
              s_d.cmd.cdb[c[4:0]] = req.data; // Bytes past 32 are consumed, not kept
            end
          end else if (p < 9'h004) begin
            s_d.cmd.outgoing_protection_count[8*p[1:0] +: 8] = req.data;
          end else begin
            s_d.cmd.incoming_protection_count[8*p[1:0] +: 8] = req.data;
          end
          s_d.idx = i + 9'h001;
          if (req.last) begin
            s_d.short_hdr = (i + 9'h001) != hl;
            s_d.fsm       = srqh_pkg::S_DECIDE;
          end else if ((i + 9'h001) == hl) begin
            s_d.fsm = srqh_pkg::S_DRAIN;
          end
        end
      end
      srqh_pkg::S_DRAIN: begin
        // Outgoing data after the header is skipped until the last beat; protection counts were already taken in S_HDR
        if (req_valid && req.last) begin
          s_d.fsm = srqh_pkg::S_DECIDE;
        end
      end
      srqh_pkg::S_DECIDE: begin
        s_d.idx           = 9'h000;
        s_d.cpl           = '0;
        s_d.cpl.queue     = s_q.cmd.queue;
        s_d.cpl.tag       = s_q.cmd.tag;
        s_d.cmd.target    = s_q.lun[1];
        s_d.cmd.unit      = {s_q.lun[2][5:0], s_q.lun[3]};
        s_d.cmd.report_luns = is_report(s_q.lun);
        s_d.fsm           = srqh_pkg::S_CPL;
        if (s_q.short_hdr || s_q.rst_pend) begin
          s_d.cpl.response = srqh_pkg::RESP_FAILURE;
        end else if (both_dir && !s_q.f_inout) begin
          s_d.cpl.response = srqh_pkg::RESP_FAILURE;
        end else if (is_report(s_q.lun)) begin
          s_d.fsm = srqh_pkg::S_EXEC;
        end else if (!is_flat(s_q.lun) || s_q.lun[1] > s_q.max_target) begin
          s_d.cpl.response = srqh_pkg::RESP_BAD_TARGET;
        end else begin
          s_d.fsm = srqh_pkg::S_EXEC;
        end
      end
      srqh_pkg::S_EXEC, srqh_pkg::S_WAIT: begin
        if (s_q.fsm == srqh_pkg::S_EXEC && exec_ready) begin
          s_d.fsm = srqh_pkg::S_WAIT;
        end
        if (s_q.fsm == srqh_pkg::S_WAIT && tgt_valid) begin
          // Target answer wins over a cancel in the same cycle
          s_d.fsm           = srqh_pkg::S_CPL;
          s_d.cpl.status    = tgt.status;
          s_d.cpl.qualifier = tgt.qualifier;
          s_d.cpl.sense_len = (tgt.sense_count > s_q.sense_size) ? s_q.sense_size : tgt.sense_count;
          s_d.cpl.residual  = (tgt.xfer_bytes > tgt.data_length) ? 32'h0 :
                              tgt.data_length - tgt.xfer_bytes;
          if ({1'b0, tgt.data_length} > {1'b0, s_q.cmd.out_len} + {1'b0, s_q.cmd.in_len}) begin
            s_d.cpl.response = srqh_pkg::RESP_OVERRUN;
          end else begin
            s_d.cpl.response = tgt.resp;
          end
        end else if (tmf_abort || tmf_reset || s_q.rst_pend) begin
          s_d.fsm          = srqh_pkg::S_CPL;
          s_d.cancel       = s_q.fsm == srqh_pkg::S_WAIT;
          s_d.cpl.response = tmf_abort ? srqh_pkg::RESP_ABORTED :
                             tmf_reset ? srqh_pkg::RESP_RESET : srqh_pkg::RESP_FAILURE;
        end
      end
      srqh_pkg::S_CPL: begin
        if (cpl_ready) begin
          s_d.fsm       = srqh_pkg::S_HDR;
          s_d.done_cnt  = s_q.done_cnt + 16'h0001;
          s_d.last_resp = s_q.cpl.response;
        end
      end
      default: begin
        s_d.fsm = srqh_pkg::S_HDR;
      end
    endcase
    // Register writes land in the data phase; a reset request set here beats its clear
    s_d.wr_pend = ahb_go && hwrite && hsize == 3'b010;
    s_d.wr_addr = haddr[7:0];
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        srqh_pkg::REG_CTRL: begin
          s_d.f_inout    = hwdata[srqh_pkg::CTRL_INOUT];
          s_d.f_pi       = hwdata[srqh_pkg::CTRL_PI];
          s_d.map_simple = hwdata[srqh_pkg::CTRL_SIMPLE];
          if (hwdata[srqh_pkg::CTRL_DEVRST]) begin
            s_d.rst_pend = 1'b1;
          end
        end
        srqh_pkg::REG_SENSE: s_d.sense_size = hwdata;
        srqh_pkg::REG_CDB:   s_d.cdb_size   = hwdata[7:0];
        srqh_pkg::REG_MAXT:  s_d.max_target = hwdata[7:0];
        default: ;
      endcase
    end
    if (unplug) begin
      s_d.rst_pend = 1'b1;
    end
    // Read data sampled in the address phase; a write just before is not yet seen
    case (haddr[7:0])
      srqh_pkg::REG_CTRL: begin
        rd[srqh_pkg::CTRL_INOUT]  = s_q.f_inout;
        rd[srqh_pkg::CTRL_PI]     = s_q.f_pi;
        rd[srqh_pkg::CTRL_SIMPLE] = s_q.map_simple;
      end
      srqh_pkg::REG_SENSE:  rd = s_q.sense_size;
      srqh_pkg::REG_CDB:    rd = {24'h000000, s_q.cdb_size};
      srqh_pkg::REG_MAXT:   rd = {24'h000000, s_q.max_target};
      srqh_pkg::REG_STATUS: rd = {8'h00, s_q.cmd.crn, s_q.last_resp, 1'b0, s_q.rst_pend, s_q.fsm};
      srqh_pkg::REG_DONE:   rd = {16'h0000, s_q.done_cnt};
      default:              rd = 32'h0000_0000;
    endcase
    if (ahb_go && !hwrite) begin
      s_d.rdata = rd;
    end
  end

  // Single state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q            <= '0;
      s_q.fsm        <= srqh_pkg::S_HDR;
      s_q.sense_size <= srqh_pkg::SENSE_RST;
      s_q.cdb_size   <= srqh_pkg::CDB_RST;
      s_q.max_target <= srqh_pkg::MAXT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = s_q.rdata;
  assign req_ready   = (s_q.fsm == srqh_pkg::S_HDR && !(s_q.rst_pend && s_q.idx == 9'h000)) ||
                       s_q.fsm == srqh_pkg::S_DRAIN;
  assign exec_valid  = s_q.fsm == srqh_pkg::S_EXEC;
  assign exec_cmd    = s_q.cmd;
  assign exec_cancel = s_q.cancel;
  assign tgt_ready   = s_q.fsm == srqh_pkg::S_WAIT;
  assign cpl_valid   = s_q.fsm == srqh_pkg::S_CPL;
  assign cpl         = s_q.cpl;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic clean;
  assign clean = s_q.fsm == srqh_pkg::S_DECIDE && !s_q.short_hdr && !s_q.rst_pend;

  sequence sq_tgt_done;
    tgt_valid && tgt_ready;
  endsequence

  sequence sq_abort_wait;
    s_q.fsm == srqh_pkg::S_WAIT ##0 (tmf_abort && !tgt_valid);
  endsequence

  // Completion always carries the queue and tag that the request arrived with
  a_same_queue: assert property (cpl_valid
    |-> cpl.queue == exec_cmd.queue && cpl.tag == exec_cmd.tag) else $error("completion on another queue");
  a_inout_fail: assert property (clean && both_dir && !s_q.f_inout
    |=> cpl_valid && cpl.response == srqh_pkg::RESP_FAILURE && !exec_valid) else $error("bidirectional not failed");
  a_bad_target: assert property (clean && !both_dir && is_flat(s_q.lun) && s_q.lun[1] > s_q.max_target
    |=> cpl_valid && cpl.response == srqh_pkg::RESP_BAD_TARGET) else $error("absent target dispatched");
  a_report_unit: assert property (clean && (!both_dir || s_q.f_inout) && is_report(s_q.lun)
    |=> exec_valid && exec_cmd.report_luns) else $error("report unit not dispatched");
  a_sense_clip: assert property (sq_tgt_done
    |=> cpl.sense_len == (($past(tgt.sense_count) > s_q.sense_size) ? s_q.sense_size : $past(tgt.sense_count)))
    else $error("sense length wrong");
  a_resid_calc: assert property (sq_tgt_done ##0 (tgt.xfer_bytes <= tgt.data_length)
    |=> cpl.residual == $past(tgt.data_length) - $past(tgt.xfer_bytes)) else $error("residual wrong");
  a_overrun_code: assert property (sq_tgt_done ##0
    ({1'b0, tgt.data_length} > {1'b0, s_q.cmd.out_len} + {1'b0, s_q.cmd.in_len})
    |=> cpl_valid && cpl.response == srqh_pkg::RESP_OVERRUN) else $error("overrun missed");
  a_abort_resp: assert property (sq_abort_wait
    |=> cpl_valid && exec_cancel && cpl.response == srqh_pkg::RESP_ABORTED) else $error("abort not reported");
  a_cfg_reset: assert property ($fell(rst)
    |-> s_q.sense_size == srqh_pkg::SENSE_RST && s_q.cdb_size == srqh_pkg::CDB_RST) else $error("config not reset");

  // Device reset waits until nothing is outstanding; checked only in cycles where no register write lands
  sequence sq_reset_idle;
    s_q.rst_pend && s_q.fsm == srqh_pkg::S_HDR && s_q.idx == 9'h000 && !s_q.wr_pend;
  endsequence

  // Target verdict passes through unless the buffers are too small
  a_status_pass: assert property (sq_tgt_done ##0
    ({1'b0, tgt.data_length} <= {1'b0, s_q.cmd.out_len} + {1'b0, s_q.cmd.in_len})
    |=> cpl_valid && cpl.response == $past(tgt.resp) && cpl.status == $past(tgt.status))
    else $error("status not passed");

  // Cancels from task management, and the device reset reload; the cancel strobe lasts a single cycle
  a_reset_resp: assert property (s_q.fsm == srqh_pkg::S_WAIT && tmf_reset && !tmf_abort && !tgt_valid
    |=> cpl_valid && exec_cancel && cpl.response == srqh_pkg::RESP_RESET) else $error("reset not reported");
  a_cancel_once: assert property (exec_cancel |=> !exec_cancel) else $error("cancel strobe too long");
  a_reload_idle: assert property (sq_reset_idle
    |=> s_q.sense_size == srqh_pkg::SENSE_RST && s_q.cdb_size == srqh_pkg::CDB_RST && !cpl_valid)
    else $error("sizes not reloaded");

endmodule : srqh_top

/* File: inc/srqh_pkg.sv */
package srqh_pkg;

  // Response codes written to the trailer
  localparam logic [7:0] RESP_OK          = 8'h00;
  localparam logic [7:0] RESP_OVERRUN     = 8'h01;
  localparam logic [7:0] RESP_ABORTED     = 8'h02;
  localparam logic [7:0] RESP_BAD_TARGET  = 8'h03;
  localparam logic [7:0] RESP_RESET       = 8'h04;
  localparam logic [7:0] RESP_BUSY        = 8'h05;
  localparam logic [7:0] RESP_TRANSPORT   = 8'h06;
  localparam logic [7:0] RESP_TARGET_FAIL = 8'h07;
  localparam logic [7:0] RESP_NEXUS       = 8'h08;
  localparam logic [7:0] RESP_FAILURE     = 8'h09;

  // Task attributes
  localparam logic [7:0] ATTR_SIMPLE          = 8'h00;
  localparam logic [7:0] ATTR_ORDERED         = 8'h01;
  localparam logic [7:0] ATTR_HEAD            = 8'h02;
  localparam logic [7:0] ATTR_AUTO_CONTINGENT = 8'h03;

  // Unit address bytes
  localparam logic [7:0] LUN_REPORT_B0 = 8'hc1;
  localparam logic [7:0] LUN_REPORT_B1 = 8'h01;
  localparam logic [7:0] LUN_FLAT_B0   = 8'h01;

  // Header byte offsets
  localparam logic [8:0] OFS_TAG  = 9'h008;
  localparam logic [8:0] OFS_ATTR = 9'h010;
  localparam logic [8:0] OFS_PRIO = 9'h011;
  localparam logic [8:0] OFS_CRN  = 9'h012;
  localparam logic [8:0] OFS_CDB  = 9'h013;
  localparam logic [8:0] PI_LEN   = 9'h008;
  localparam int         CDB_KEEP = 32;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SENSE  = 8'h04;
  localparam logic [7:0] REG_CDB    = 8'h08;
  localparam logic [7:0] REG_MAXT   = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_DONE   = 8'h14;

  // Control bit positions
  localparam int CTRL_INOUT  = 0;
  localparam int CTRL_PI     = 3;
  localparam int CTRL_SIMPLE = 4;
  localparam int CTRL_DEVRST = 8;

  // Values after reset
  localparam logic [31:0] SENSE_RST = 32'h0000_0060;
  localparam logic [7:0]  CDB_RST   = 8'h20;
  localparam logic [7:0]  MAXT_RST  = 8'hff;

  typedef enum logic [5:0] {
    S_HDR    = 6'h01,
    S_DRAIN  = 6'h02,
    S_DECIDE = 6'h04,
    S_EXEC   = 6'h08,
    S_WAIT   = 6'h10,
    S_CPL    = 6'h20
  } srqh_fsm_t;

  typedef struct packed {
    logic [7:0]  data;
    logic        last;
    logic [3:0]  queue;
    logic [31:0] out_len;
    logic [31:0] in_len;
  } srqh_beat_t;

  typedef struct packed {
    logic [3:0]            queue;
    logic [63:0]           tag;
    logic                  report_luns;
    logic [7:0]            target;
    logic [13:0]           unit;
    logic [7:0]            attr;
    logic [7:0]            prio;
    logic [7:0]            crn;
    logic [7:0]            cdb_len;
    logic [31:0][7:0]      cdb;
    logic [31:0]           outgoing_protection_count;
    logic [31:0]           incoming_protection_count;
    logic [31:0]           out_len;
    logic [31:0]           in_len;
  } srqh_exec_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  resp;
    logic [15:0] qualifier;
    logic [31:0] sense_count;
    logic [31:0] data_length;
    logic [31:0] xfer_bytes;
  } srqh_tgt_t;

  typedef struct packed {
    logic [3:0]  queue;
    logic [63:0] tag;
    logic [31:0] sense_len;
    logic [31:0] residual;
    logic [15:0] qualifier;
    logic [7:0]  status;
    logic [7:0]  response;
  } srqh_cpl_t;

endpackage : srqh_pkg

/* File: tb/srqh_tgt_model.sv */
// Emulated target behind the request handler
module srqh_tgt_model (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                exec_valid,
  output logic                     exec_ready,
  input  wire logic                exec_cancel,
  input  wire logic                tgt_ready,
  output logic                     tgt_valid,
  output srqh_pkg::srqh_tgt_t      tgt,
  input  wire srqh_pkg::srqh_tgt_t ans,
  input  wire logic [7:0]          dly
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend;
  logic [7:0] cnt;

  // Always takes the command at once
  assign exec_ready = 1'b1;

  // Answer dly+1 cycles after taking the command; outside an answer the bus shows junk
  always_ff @(posedge mclk) begin
    if (rst || exec_cancel || (tgt_valid && tgt_ready)) begin
      pend      <= 1'b0;
      tgt_valid <= 1'b0;
      tgt       <= ~ans;
    end else if (exec_valid) begin
      pend <= 1'b1;
      cnt  <= 8'h00;
    end else if (pend && !tgt_valid) begin
      cnt <= cnt + 8'h01;
      if (cnt >= dly) begin
        tgt_valid <= 1'b1;
        tgt       <= ans;
      end
    end
  end
endmodule : srqh_tgt_model

/* File: tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] LOK = 64'h0107_4003_0000_0000;
  logic mclk, rst, hsel, hwrite, hreadyout, hresp, req_valid, req_ready, exec_valid, exec_ready;
  logic exec_cancel, tgt_valid, tgt_ready, tmf_abort, tmf_reset, unplug, cpl_valid, cpl_ready;
  logic pi_on, saw_cancel;
  logic [31:0] haddr, hwdata, hrdata, pio, pii;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  dly, crn;
  logic [3:0]  ql;
  logic [63:0] tag;
  int          n_fail, checks_done, cdb_n;
  srqh_pkg::srqh_beat_t req;
  srqh_pkg::srqh_exec_t exec_cmd;
  srqh_pkg::srqh_tgt_t  tgt, ans;
  srqh_pkg::srqh_cpl_t  cpl;

  srqh_top srqh_top_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .exec_valid(exec_valid), .exec_ready(exec_ready), .exec_cmd(exec_cmd), .exec_cancel(exec_cancel),
    .tgt_valid(tgt_valid), .tgt_ready(tgt_ready), .tgt(tgt), .tmf_abort(tmf_abort),
    .tmf_reset(tmf_reset), .unplug(unplug), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready), .cpl(cpl));

  srqh_tgt_model srqh_tgt_model_i (.mclk(mclk), .rst(rst), .exec_valid(exec_valid),
    .exec_ready(exec_ready), .exec_cancel(exec_cancel), .tgt_ready(tgt_ready),
    .tgt_valid(tgt_valid), .tgt(tgt), .ans(ans), .dly(dly));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Cancel lasts one cycle, so latch it
  always @(posedge mclk) if (exec_cancel === 1'b1) saw_cancel <= 1'b1;

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One AHB single transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask : rdc

  // Header bytes in wire order; nb above zero cuts the request short
  task automatic send(input logic [63:0] lun, input logic [7:0] at, input logic [3:0] q,
                      input logic [31:0] ol, input logic [31:0] il, input int nb);
    logic [7:0] b[$];
    tag = tag + 64'h0101_0101_0101_0101;
    ql  = q;
    for (int i = 7; i >= 0; i--) b.push_back(lun[i*8+:8]);
    for (int i = 0; i < 8; i++) b.push_back(tag[i*8+:8]);
    b.push_back(at);
    b.push_back(8'h00);
    b.push_back(crn);
    for (int i = 0; i < cdb_n; i++) b.push_back(8'h40 + 8'(i));
    for (int i = 0; pi_on && i < 8; i++) b.push_back(i < 4 ? pio[i*8+:8] : pii[(i-4)*8+:8]);
    b.push_back(8'h5a);
    if (nb > 0) b = b[0:nb-1];
    @(posedge mclk);
    foreach (b[i]) begin
      req       <= '{data: b[i], last: (i == b.size() - 1), queue: q, out_len: ol, in_len: il};
      req_valid <= 1'b1;
      do @(posedge mclk); while (req_ready !== 1'b1);
    end
    req_valid <= 1'b0;
  endtask : send

  task automatic wait_cpl(input logic [7:0] r);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (cpl_valid !== 1'b1 && k < 300);
    chk("cpl_valid", 64'h1, cpl_valid);
    chk("cpl_queue", ql, cpl.queue);
    chk("cpl_tag", tag, cpl.tag);
    chk("response", r, cpl.response);
  endtask : wait_cpl

  task automatic run(input logic [63:0] lun, input logic [7:0] r, input logic [7:0] at = 0,
                     input logic [3:0] q = 1, input logic [31:0] ol = 0, input logic [31:0] il = 128,
                     input int nb = 0);
    send(lun, at, q, ol, il, nb);
    wait_cpl(r);
  endtask : run

  task automatic t_regs();
    rdc("sense_size", srqh_pkg::REG_SENSE, 32'h60);
    rdc("cdb_size", srqh_pkg::REG_CDB, 32'h20);
    rdc("max_target", srqh_pkg::REG_MAXT, 32'hff);
    rdc("unmapped", 8'h40, 32'h0);
    wr(srqh_pkg::REG_SENSE, 32'h10);
    rdc("sense_size_wr", srqh_pkg::REG_SENSE, 32'h10);
  endtask : t_regs

  // Status not GOOD still completes OK; sense clipped to the buffer
  task automatic t_ok();
    ans <= '{status: 8'h02, resp: 8'h00, qualifier: 16'h0, sense_count: 32'd18, data_length: 32'd100,
             xfer_bytes: 32'd60};
    crn = 8'hff;
    run(LOK, 8'h00, 8'h02, 4'h5);
    chk("sense_len", 64'd16, cpl.sense_len);
    chk("residual", 64'd40, cpl.residual);
    chk("status", 64'h02, cpl.status);
    chk("target", 64'h07, exec_cmd.target);
    chk("unit", 64'h3, exec_cmd.unit);
    chk("crn", 64'hff, exec_cmd.crn);
    chk("cdb_len", 64'd32, exec_cmd.cdb_len);
    crn = 8'h00;
    ans <= '{status: 8'h00, resp: 8'h00, qualifier: 16'h0, sense_count: 32'd5, data_length: 32'd100,
             xfer_bytes: 32'd150};
    run(LOK, 8'h00, 8'h00, 4'h9);
    chk("sense_len", 64'd5, cpl.sense_len);
    chk("residual", 64'd0, cpl.residual);
  endtask : t_ok

  // Target failure codes pass through untouched
  task automatic t_codes();
    logic [7:0] c[4] = '{8'h05, 8'h06, 8'h07, 8'h08};
    foreach (c[i]) begin
      ans.resp <= c[i];
      run(LOK, c[i]);
    end
    ans.resp        <= 8'h00;
    ans.data_length <= 32'd300;
    run(LOK, srqh_pkg::RESP_OVERRUN, 8'h00, 4'h2, 32'd100, 32'd0);
    ans.data_length <= 32'd100;
  endtask : t_codes

  task automatic t_addr();
    run(64'h0207_0001_0000_0000, srqh_pkg::RESP_BAD_TARGET);
    run(64'h0107_0001_0000_0001, srqh_pkg::RESP_BAD_TARGET);
    wr(srqh_pkg::REG_MAXT, 32'h3);
    run(LOK, srqh_pkg::RESP_BAD_TARGET);
    wr(srqh_pkg::REG_MAXT, 32'hff);
    for (int a = 0; a < 4; a++) begin
      run(LOK, 8'h00, 8'(a));
      chk("attr", a, exec_cmd.attr);
    end
    wr(srqh_pkg::REG_CTRL, 32'h10);
    run(64'hc101_0000_0000_0000, 8'h00, 8'h02);
    chk("report_luns", 64'h1, exec_cmd.report_luns);
    chk("attr_mapped", 64'h0, exec_cmd.attr);
    wr(srqh_pkg::REG_CTRL, 32'h0);
  endtask : t_addr

  task automatic t_bidir();
    ans.data_length <= 32'd8;
    run(LOK, srqh_pkg::RESP_FAILURE, 8'h00, 4'h3, 32'd4, 32'd4);
    wr(srqh_pkg::REG_CTRL, 32'h1);
    run(LOK, 8'h00, 8'h00, 4'h3, 32'd4, 32'd4);
    wr(srqh_pkg::REG_CTRL, 32'h0);
    ans.data_length <= 32'd100;
  endtask : t_bidir

  // Short command block plus protection counts
  task automatic t_pi();
    wr(srqh_pkg::REG_CTRL, 32'h8);
    wr(srqh_pkg::REG_CDB, 32'h6);
    cdb_n = 6;
    pi_on = 1'b1;
    pio   = 32'd12;
    pii   = 32'd34;
    run(LOK, 8'h00);
    chk("out_prot_count", 64'd12, exec_cmd.outgoing_protection_count);
    chk("in_prot_count", 64'd34, exec_cmd.incoming_protection_count);
    chk("cdb_len", 64'd6, exec_cmd.cdb_len);
    run(LOK, srqh_pkg::RESP_FAILURE, 8'h00, 4'h1, 32'd0, 32'd128, 20);
    pi_on = 1'b0;
    cdb_n = 32;
    wr(srqh_pkg::REG_CDB, 32'h20);
    wr(srqh_pkg::REG_CTRL, 32'h0);
  endtask : t_pi

  // Cancel while the target is still busy
  task automatic t_cancel(input logic [2:0] s, input logic [7:0] r);
    int k;
    dly        <= 8'd60;
    saw_cancel <= 1'b0;
    send(LOK, 8'h00, 4'h6, 32'd0, 32'd128, 0);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (tgt_ready !== 1'b1 && k < 100);
    chk("tgt_ready", 64'h1, tgt_ready);
    {tmf_abort, tmf_reset, unplug} <= s;
    @(posedge mclk);
    {tmf_abort, tmf_reset, unplug} <= 3'b000;
    wait_cpl(r);
    @(posedge mclk);
    chk("cancel_pulse", 64'h1, saw_cancel);
  endtask : t_cancel

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    {rst, hsel, hwrite, req_valid, tmf_abort, tmf_reset, unplug, cpl_ready, pi_on} = 9'b100000010;
    {haddr, hwdata, pio, pii} = '0;
    {htrans, hsize, dly, crn} = {2'b00, 3'b010, 8'h00, 8'h00};
    {req, ans, saw_cancel, ql} = '0;
    tag = 64'h8877_6655_4433_2211;
    cdb_n = 32;
    n_fail = 0;
    checks_done = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_ok();
    t_codes();
    t_addr();
    t_bidir();
    t_pi();
    t_cancel(3'b100, srqh_pkg::RESP_ABORTED);
    t_cancel(3'b010, srqh_pkg::RESP_RESET);
    t_cancel(3'b001, srqh_pkg::RESP_FAILURE);
    rdc("sense_reload", srqh_pkg::REG_SENSE, 32'h60);
    tally_and_finish();
  end

  // Hang guard, far beyond the fewer than two thousand cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule : testbench
